// file: core/nfh_bus_cycle.sv
// Single asynchronous bus cycle engine: one write or one read
`timescale 1ns/100ps
`default_nettype none
module nfh_bus_cycle
    import nfh_pkg::*;
(
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst_n,
    // Cycle request
    input  wire logic              start,
    input  wire logic              is_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    output logic                   done,
    output logic [DATA_W-1:0]      rdata,
    // Flash pins
    input  wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0]      dq_out,
    output logic                   dq_oe,
    output logic [ADDR_W-1:0]      addr_pin,
    output logic                   chip_select_n,
    output logic                   write_strobe_n,
    output logic                   output_enable_n
);
    typedef enum logic [1:0] {NFH_BC_IDLE, NFH_BC_ACT, NFH_BC_GAP} nfh_bc_t;
    nfh_bc_t          st_q, st_d;
    logic [7:0]       cnt_q, cnt_d;
    logic [DATA_W-1:0] rd_q, rd_d, dqo_q, dqo_d;
    logic [ADDR_W-1:0] a_q, a_d;
    logic             wr_q, wr_d, done_q, done_d;

    // Next state: CS and WE fall together so address latches on the later edge,
    // data on the earlier rising edge; both rise together here
    always_comb
    begin
        st_d = st_q; cnt_d = cnt_q; rd_d = rd_q; a_d = a_q;
        dqo_d = dqo_q; wr_d = wr_q; done_d = 1'b0;
        unique case (st_q)
            NFH_BC_IDLE:
                if (start)
                begin
                    a_d = addr; dqo_d = wdata; wr_d = is_write;
                    cnt_d = is_write ? 8'(WE_LOW_CYC) : 8'(READ_CYC);
                    st_d = NFH_BC_ACT;
                end
            NFH_BC_ACT:
                if (cnt_q <= 8'h01)
                begin
                    if (!wr_q)
                        rd_d = dq_in;
                    cnt_d = 8'(WE_HIGH_CYC);
                    st_d = NFH_BC_GAP;
                end
                else
                    cnt_d = cnt_q - 8'h01;
            NFH_BC_GAP:
                if (cnt_q <= 8'h01)
                begin
                    done_d = 1'b1;
                    st_d = NFH_BC_IDLE;
                end
                else
                    cnt_d = cnt_q - 8'h01;
        endcase
    end

    // Registers
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            st_q <= NFH_BC_IDLE; cnt_q <= 8'h00; rd_q <= '0; a_q <= '0;
            dqo_q <= '0; wr_q <= 1'b0; done_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d; cnt_q <= cnt_d; rd_q <= rd_d; a_q <= a_d;
            dqo_q <= dqo_d; wr_q <= wr_d; done_q <= done_d;
        end
    end

    // Pin drive from state; OE stays high for writes
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            chip_select_n <= 1'b1; write_strobe_n <= 1'b1;
            output_enable_n <= 1'b1; dq_oe <= 1'b0;
        end
        else
        begin
            chip_select_n   <= !(st_d == NFH_BC_ACT);
            write_strobe_n  <= !(st_d == NFH_BC_ACT && wr_d);
            output_enable_n <= !(st_d == NFH_BC_ACT && !wr_d);
            dq_oe           <= (st_d != NFH_BC_IDLE) && wr_d;
        end
    end

    assign done     = done_q;
    assign rdata    = rd_q;
    assign dq_out   = dqo_q;
    assign addr_pin = a_q;
endmodule
`default_nettype wire

// file: core/nfh_host.sv
// Host controller driving a parallel NOR flash through its pins
`timescale 1ns/100ps
`default_nettype none
module nfh_host
    import nfh_pkg::*;
#(
    parameter int MAX_WORDS = BUF_MAX_W
)
(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    // Command port
    input  wire logic                   req_valid,
    input  wire nfh_pkg::nfh_op_t       req_op,
    input  wire logic [nfh_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [nfh_pkg::DATA_W-1:0] req_data,
    input  wire logic [4:0]             req_count,
    input  wire logic [63:0]            req_sect_mask,
    input  wire logic                   accel_req,
    output logic                        req_ready,
    output logic                        wdata_pop,
    output logic                        resp_valid,
    output logic [nfh_pkg::DATA_W-1:0]  resp_data,
    output logic                        resp_error,
    output logic                        bypass_active,
    output logic                        op_cut,
    // Flash pins
    input  wire logic [nfh_pkg::DATA_W-1:0] dq_in,
    output logic [nfh_pkg::DATA_W-1:0]  dq_out,
    output logic                        dq_oe,
    output logic [nfh_pkg::ADDR_W-1:0]  addr_pin,
    output logic                        chip_select_n,
    output logic                        write_strobe_n,
    output logic                        output_enable_n,
    output logic                        hardware_clear_n,
    output logic                        accel_hv_en,
    output logic                        width_select_n
);
    import nfh_pkg::*;

    typedef enum logic [2:0] {NFH_IDLE, NFH_SEQ, NFH_WAIT, NFH_CLR, NFH_REC} nfh_st_t;

    nfh_st_t            st_q, st_d;
    nfh_op_t            op_q, op_d;
    logic [3:0]         step_q, step_d;
    logic [5:0]         nsteps_q, nsteps_d;
    logic [ADDR_W-1:0]  a_q, a_d;
    logic [DATA_W-1:0]  d_q, d_d, resp_q, resp_d;
    logic [4:0]         cnt_q, cnt_d;
    logic [63:0]        mask_q, mask_d;
    logic [CNT_W-1:0]   tmr_q, tmr_d;
    logic               byp_q, byp_d, cut_q, cut_d, rv_q, rv_d, err_q, err_d;
    logic               rdy_q, rdy_d, pop_q, pop_d, clr_q, clr_d, hv_q, hv_d;
    logic               bc_start, bc_wr, bc_done;
    logic [ADDR_W-1:0]  bc_addr;
    logic [DATA_W-1:0]  bc_wdata, bc_rdata;
    logic [5:0]         low_sect;

    // Lowest pending sector of a multi-sector erase
    always_comb
    begin
        low_sect = 6'h00;
        for (int i = 63; i >= 0; i--)
            if (mask_q[i])
                low_sect = 6'(i);
    end

    // Cycle engine
    nfh_bus_cycle u_cycle (
        .clock           (clock),
        .rst_n           (rst_n),
        .start           (bc_start),
        .is_write        (bc_wr),
        .addr            (bc_addr),
        .wdata           (bc_wdata),
        .done            (bc_done),
        .rdata           (bc_rdata),
        .dq_in           (dq_in),
        .dq_out          (dq_out),
        .dq_oe           (dq_oe),
        .addr_pin        (addr_pin),
        .chip_select_n   (chip_select_n),
        .write_strobe_n  (write_strobe_n),
        .output_enable_n (output_enable_n)
    );

    // Sequence step decoder: unlock pair, then command, then payload; reads, exit and bypass programs have no unlock pair
    always_comb
    begin
        bc_wr = 1'b1;
        bc_addr = UNLOCK_A1;
        bc_wdata = UNLOCK_D1;
        if (step_q == 4'h1 || step_q == 4'h4)
        begin
            bc_addr = UNLOCK_A2;
            bc_wdata = UNLOCK_D2;
        end
        unique case (op_q)
            NFH_OP_READ:
            begin
                bc_wr = 1'b0;
                bc_addr = a_q;
            end
            NFH_OP_PROG:
                if (step_q == 4'h2 || (byp_q && step_q == 4'h0))
                    bc_wdata = CMD_PROG;
                else if (step_q == 4'h3 || (byp_q && step_q == 4'h1))
                begin
                    bc_addr = a_q;
                    bc_wdata = d_q;
                end
            NFH_OP_ERASE_SECT, NFH_OP_ERASE_MORE, NFH_OP_ERASE_CHIP:
                if (step_q == 4'h2)
                    bc_wdata = CMD_ERASE;
                else if (step_q == 4'h5)
                begin
                    if (op_q == NFH_OP_ERASE_CHIP)
                        bc_wdata = CMD_CHIP;
                    else
                    begin
                        bc_addr = (op_q == NFH_OP_ERASE_SECT) ? a_q
                                : ADDR_W'({low_sect, 15'h0000});
                        bc_wdata = CMD_SECT;
                    end
                end
            NFH_OP_IDENT:
                if (step_q == 4'h2)
                    bc_wdata = CMD_IDENT;
            NFH_OP_BYP_ENTER:
                if (step_q == 4'h2)
                    bc_wdata = CMD_BYP;
            NFH_OP_EXIT:
                bc_wdata = CMD_EXIT;
            NFH_OP_BUF_PROG:
                if (step_q == 4'h2)
                begin
                    bc_addr = a_q;
                    bc_wdata = CMD_BUF;
                end
                else if (step_q == 4'h3)
                begin
                    bc_addr = a_q;
                    bc_wdata = DATA_W'(cnt_q);                     // Count minus one
                end
                else if (step_q == 4'h4 || step_q == 4'h5)
                begin
                    bc_addr = a_q;
                    bc_wdata = (step_q == 4'h4) ? d_q : CMD_BUFGO;
                end
            NFH_OP_CLEAR:
                bc_wr = 1'b1;
        endcase
        bc_start = (st_q == NFH_SEQ);
    end

    // Main controller
    always_comb
    begin
        st_d = st_q; op_d = op_q; step_d = step_q; nsteps_d = nsteps_q;
        a_d = a_q; d_d = d_q; resp_d = resp_q; cnt_d = cnt_q; mask_d = mask_q;
        tmr_d = tmr_q; byp_d = byp_q; cut_d = cut_q; err_d = 1'b0; rv_d = 1'b0;
        rdy_d = 1'b0; pop_d = 1'b0; clr_d = clr_q;
        // High voltage only while accelerated programs are requested
        hv_d = accel_req && (st_q == NFH_IDLE || op_q == NFH_OP_PROG) && st_q != NFH_CLR;
        if (hv_q && !hv_d)
            byp_d = 1'b0;
        else if (hv_q)
            byp_d = 1'b1;
        unique case (st_q)
            NFH_IDLE:
            begin
                rdy_d = 1'b1;
                if (req_valid && rdy_q)
                begin
                    rdy_d = 1'b0; op_d = req_op; a_d = req_addr; d_d = req_data;
                    step_d = 4'h0; mask_d = req_sect_mask; cnt_d = req_count;
                    st_d = NFH_SEQ;
                    unique case (req_op)
                        NFH_OP_READ, NFH_OP_EXIT: nsteps_d = 6'd1;
                        NFH_OP_PROG:      nsteps_d = byp_q ? 6'd2 : 6'd4;
                        NFH_OP_IDENT, NFH_OP_BYP_ENTER: nsteps_d = 6'd3;
                        NFH_OP_BUF_PROG:  nsteps_d = 6'd6;
                        NFH_OP_CLEAR:     nsteps_d = 6'd0;
                        default:          nsteps_d = 6'd6;
                    endcase
                    if (req_op == NFH_OP_BUF_PROG && int'(req_count) >= MAX_WORDS)
                    begin
                        err_d = 1'b1; rv_d = 1'b1; rdy_d = 1'b1;
                        st_d = NFH_IDLE;
                    end
                    else if (req_op == NFH_OP_CLEAR)
                    begin
                        clr_d = 1'b1; tmr_d = CNT_W'(CLEAR_CYC);
                        st_d = NFH_CLR;
                    end
                    else if (req_op == NFH_OP_ERASE_MORE && req_sect_mask == 64'h0)
                    begin
                        err_d = 1'b1; rv_d = 1'b1; rdy_d = 1'b1;
                        st_d = NFH_IDLE;
                    end
                end
            end
            NFH_SEQ:
                st_d = NFH_WAIT;
            NFH_WAIT:
                if (bc_done)
                begin
                    if (op_q == NFH_OP_BUF_PROG && step_q == 4'h4)
                    begin
                        pop_d = 1'b1; d_d = req_data;              // Next word
                        a_d = a_q + 22'h000001;
                        if (cnt_q != 5'h00)
                            cnt_d = cnt_q - 5'h01;
                        else
                            step_d = 4'h5;
                        st_d = NFH_SEQ;
                    end
                    else if (6'(step_q) + 6'd1 >= nsteps_q)
                    begin
                        resp_d = bc_rdata; rv_d = 1'b1;
                        if (op_q == NFH_OP_ERASE_MORE)
                            mask_d[low_sect] = 1'b0;
                        if (op_q == NFH_OP_ERASE_MORE && (mask_d != 64'h0))
                        begin
                            rv_d = 1'b0; step_d = 4'h5; st_d = NFH_SEQ; // Within erase window
                        end
                        else
                        begin
                            if (op_q == NFH_OP_BYP_ENTER)
                                byp_d = 1'b1;
                            if (op_q == NFH_OP_EXIT && !hv_q)
                                byp_d = 1'b0;
                            cut_d = 1'b0; rdy_d = 1'b1; st_d = NFH_IDLE;
                        end
                    end
                    else
                    begin
                        step_d = step_q + 4'h1;
                        if (op_q == NFH_OP_PROG && byp_q && step_q == 4'h0)
                            step_d = 4'h1;
                        st_d = NFH_SEQ;
                    end
                end
            NFH_CLR:
                if (tmr_q <= CNT_W'(1))
                begin
                    clr_d = 1'b0; tmr_d = CNT_W'(CLEAR_REC_CYC);
                    byp_d = hv_q;
                    st_d = NFH_REC;
                end
                else
                    tmr_d = tmr_q - CNT_W'(1);
            NFH_REC:
                if (tmr_q <= CNT_W'(1))
                begin
                    rv_d = 1'b1; rdy_d = 1'b1; st_d = NFH_IDLE;
                end
                else
                    tmr_d = tmr_q - CNT_W'(1);
        endcase
    end

    // State registers; the clear pulse floats the device outputs, so reads stall
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            st_q <= NFH_IDLE; op_q <= NFH_OP_READ; step_q <= 4'h0; nsteps_q <= 6'd0;
            a_q <= '0; d_q <= '0; resp_q <= '0; cnt_q <= 5'h00; mask_q <= 64'h0;
            tmr_q <= '0; byp_q <= 1'b0; cut_q <= 1'b0; rv_q <= 1'b0; err_q <= 1'b0;
            rdy_q <= 1'b0; pop_q <= 1'b0; clr_q <= 1'b0; hv_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d; op_q <= op_d; step_q <= step_d; nsteps_q <= nsteps_d;
            a_q <= a_d; d_q <= d_d; resp_q <= resp_d; cnt_q <= cnt_d; mask_q <= mask_d;
            tmr_q <= tmr_d; byp_q <= byp_d; cut_q <= cut_d; rv_q <= rv_d; err_q <= err_d;
            rdy_q <= rdy_d; pop_q <= pop_d; clr_q <= clr_d; hv_q <= hv_d;
        end
    end

    // Port drive; word mode fixed, the top pin is never an address input
    assign req_ready        = rdy_q;
    assign wdata_pop        = pop_q;
    assign resp_valid       = rv_q;
    assign resp_data        = resp_q;
    assign resp_error       = err_q;
    assign bypass_active    = byp_q;
    assign op_cut           = cut_q;
    assign hardware_clear_n = !clr_q;
    assign accel_hv_en      = hv_q;
    assign width_select_n   = 1'b1;
endmodule
`default_nettype wire

// file: core/nfh_pkg.sv
// Package: constants for the parallel NOR flash host controller
package nfh_pkg;
    // Pin and field widths
    localparam int ADDR_W     = 22;
    localparam int DATA_W     = 16;
    localparam int SECT_W     = 6;
    localparam int SECT_LSB   = 15;
    localparam int BUF_MAX_W  = 16;
    localparam int BUF_MAX_B  = 32;
    localparam int CNT_W      = 16;
    // Clock rate and timings
    localparam int CLK_PS        = 8000;
    localparam int ACCESS_NS     = 70;
    localparam int CE_ACCESS_NS  = 70;
    localparam int SLEEP_ADD_NS  = 30;
    localparam int CLEAR_NS      = 500;
    localparam int CLEAR_REC_NS  = 200;
    localparam int WE_PULSE_NS   = 35;
    localparam int WE_HIGH_NS    = 30;
    localparam int ACCESS_CYC    = (ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CE_ACCESS_CYC = (CE_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int READ_CYC      = (ACCESS_CYC > CE_ACCESS_CYC) ? ACCESS_CYC : CE_ACCESS_CYC;
    localparam int CLEAR_CYC     = (CLEAR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int CLEAR_REC_CYC = (CLEAR_REC_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WE_LOW_CYC    = (WE_PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int WE_HIGH_CYC   = (WE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    // Unlock addresses and command codes (word mode)
    localparam logic [ADDR_W-1:0] UNLOCK_A1 = 22'h000555;
    localparam logic [ADDR_W-1:0] UNLOCK_A2 = 22'h0002aa;
    localparam logic [DATA_W-1:0] UNLOCK_D1 = 16'h00aa;
    localparam logic [DATA_W-1:0] UNLOCK_D2 = 16'h0055;
    localparam logic [DATA_W-1:0] CMD_PROG  = 16'h00a0;
    localparam logic [DATA_W-1:0] CMD_ERASE = 16'h0080;
    localparam logic [DATA_W-1:0] CMD_SECT  = 16'h0030;
    localparam logic [DATA_W-1:0] CMD_CHIP  = 16'h0010;
    localparam logic [DATA_W-1:0] CMD_IDENT = 16'h0090;
    localparam logic [DATA_W-1:0] CMD_BYP   = 16'h0020;
    localparam logic [DATA_W-1:0] CMD_BUF   = 16'h0025;
    localparam logic [DATA_W-1:0] CMD_BUFGO = 16'h0029;
    localparam logic [DATA_W-1:0] CMD_EXIT  = 16'h00f0;
    // Host operations
    typedef enum logic [3:0] {
        NFH_OP_READ, NFH_OP_PROG, NFH_OP_ERASE_SECT, NFH_OP_ERASE_MORE,
        NFH_OP_ERASE_CHIP, NFH_OP_IDENT, NFH_OP_EXIT, NFH_OP_BYP_ENTER,
        NFH_OP_BUF_PROG, NFH_OP_CLEAR
    } nfh_op_t;
endpackage

// file: verif/nfh_flash_model.sv
// Behavioural flash device facing the host pins
`timescale 1ns/100ps
`default_nettype none
module nfh_flash_model
    import nfh_pkg::*;
#(
    parameter logic [15:0] ID_CODE = 16'h005a  // Arbitrary value
)
(
    // Host pins
    input  wire logic [nfh_pkg::DATA_W-1:0] dq_out,
    input  wire logic                       dq_oe,
    input  wire logic [nfh_pkg::ADDR_W-1:0] addr_pin,
    input  wire logic                       chip_select_n,
    input  wire logic                       write_strobe_n,
    input  wire logic                       output_enable_n,
    input  wire logic                       hardware_clear_n,
    // Data pins and bookkeeping
    output logic [nfh_pkg::DATA_W-1:0]      dq_in,
    output int                              wr_cnt,
    output int                              bad_cnt,
    output logic [nfh_pkg::SECT_W-1:0]      last_sect
);
    logic [15:0] mem [int];
    logic [15:0] prev_d = 16'h0000;
    logic [15:0] last_d = 16'h0000;
    logic [21:0] wa = 22'h000000;
    logic        ident = 1'b0;
    logic        valid = 1'b0;
    logic        armed = 1'b0;
    int          left = 0;
    wire         wr_n = write_strobe_n | chip_select_n;
    wire         rd_on = !chip_select_n && !output_enable_n && hardware_clear_n;
    initial wr_cnt = 0;
    initial bad_cnt = 0;
    initial last_sect = 6'h00;
    // Address on the later fall, data on the earlier rise; the address is read
    // a little late as it moves in the same step as the strobes
    always @(negedge wr_n)
    begin
        #1 wa = addr_pin;
        armed = 1'b1;
    end
    // Rise out of the unknown start-up level is no write
    always @(posedge wr_n)
    begin
        if (hardware_clear_n && armed)
        begin
            wr_cnt++;
            if (!output_enable_n || !dq_oe) bad_cnt++;
            if (prev_d == CMD_PROG || left > 0) mem[wa] = dq_out;
            else if (dq_out == CMD_IDENT) ident = 1'b1;
            else if (dq_out == CMD_EXIT) ident = 1'b0;
            else if (dq_out == CMD_SECT) last_sect = wa[20:15];
            left = (prev_d == CMD_BUF) ? int'(dq_out) + 1 : ((left > 0) ? left - 1 : 0);
            prev_d = dq_out;
        end
    end
    // Clear drops a half-written command sequence, but not the buffer words left, and returns to array reads
    always @(negedge hardware_clear_n)
    begin
        ident = 1'b0;
        prev_d = 16'h0000;
    end
    // Data appears only after the full access time
    always @(posedge rd_on)
    begin
        #(ACCESS_NS);
        last_d = ident ? ID_CODE : (mem.exists(addr_pin) ? mem[addr_pin] : 16'hffff);
        valid = rd_on;
    end
    always @(negedge rd_on) valid = 1'b0;
    // Undriven pins show the inverse so a stale value never passes
    assign dq_in = dq_oe ? dq_out : (valid ? last_d : ~last_d);
endmodule
`default_nettype wire

// file: verif/nfh_host_chk.sv
// Checker of the host controller's flash pin behaviour
`timescale 1ns/100ps
`default_nettype none
module nfh_host_chk
    import nfh_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Request side
    input wire logic accel_req,
    input wire logic resp_valid,
    input wire logic resp_error,
    input wire logic bypass_active,
    // Flash pins
    input wire logic dq_oe,
    input wire logic chip_select_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic hardware_clear_n,
    input wire logic accel_hv_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Low cycles of the clear pulse, saturating so it never wraps
    logic [7:0] clr_q;
    logic [7:0] clr_d;
    always_comb clr_d = hardware_clear_n ? 8'h00 : ((clr_q == 8'hff) ? clr_q : clr_q + 8'h01);
    always_ff @(posedge clock) clr_q <= rst_n ? clr_d : 8'h00;
    wr_levels_a: assert property (!write_strobe_n |-> !chip_select_n && output_enable_n && dq_oe)
        else $error("write strobe without select, output-enable high and data drive");
    rd_no_fight_a: assert property (!output_enable_n |-> write_strobe_n && !dq_oe)
        else $error("host drives data while reading");
    rd_wait_a: assert property ($fell(output_enable_n) |-> ##1 !output_enable_n [*8])
        else $error("read ended before the access time");
    wr_pulse_a: assert property ($fell(write_strobe_n) |-> !write_strobe_n [*5] ##1 write_strobe_n)
        else $error("write pulse length wrong");
    clr_width_a: assert property ($rose(hardware_clear_n) |-> clr_q >= CLEAR_CYC)
        else $error("clear pulse too short");
    clr_quiet_a: assert property (!hardware_clear_n |-> chip_select_n && write_strobe_n && !dq_oe)
        else $error("bus activity during clear");
    hv_cause_a: assert property ($rose(accel_hv_en) |-> $past(accel_req))
        else $error("high voltage without request");
    hv_bypass_a: assert property ($rose(accel_hv_en) |-> ##[0:2] bypass_active)
        else $error("high voltage did not give two-cycle mode");
    hv_leave_a: assert property ($fell(accel_hv_en) |-> ##[0:2] !bypass_active)
        else $error("two-cycle mode kept after high voltage removed");
    err_pulse_a: assert property (resp_error |-> resp_valid ##1 !resp_valid)
        else $error("refusal not a one-cycle response");
endmodule
bind nfh_host nfh_host_chk u_chk (.clock(clock), .rst_n(rst_n), .accel_req(accel_req),
    .resp_valid(resp_valid), .resp_error(resp_error), .bypass_active(bypass_active), .dq_oe(dq_oe),
    .chip_select_n(chip_select_n), .write_strobe_n(write_strobe_n), .output_enable_n(output_enable_n),
    .hardware_clear_n(hardware_clear_n), .accel_hv_en(accel_hv_en));
`default_nettype wire

// file: verif/nfh_host_tb.sv
// Self-checking bench for the flash host controller
`timescale 1ns/100ps
`default_nettype none
module nfh_host_tb;
    import nfh_pkg::*;
    logic clock = 1'b0, rst_n = 1'b0, req_valid = 1'b0, accel_req = 1'b0;
    nfh_op_t req_op = NFH_OP_READ;
    logic [ADDR_W-1:0] req_addr = 22'h000000, addr_pin;
    logic [DATA_W-1:0] req_data = 16'h0000, resp_data, dq_in, dq_out, got_d;
    logic [4:0] req_count = 5'h00;
    logic [63:0] req_sect_mask = 64'h0000000000000000;
    logic req_ready, wdata_pop, resp_valid, resp_error, bypass_active, op_cut, got_e;
    logic dq_oe, chip_select_n, write_strobe_n, output_enable_n, hardware_clear_n, accel_hv_en, width_select_n;
    logic [SECT_W-1:0] last_sect;
    int wr_cnt, bad_cnt, n, k, err_count = 0, tests_run = 0;
    nfh_host dut (.clock, .rst_n, .req_valid, .req_op, .req_addr, .req_data, .req_count, .req_sect_mask,
        .accel_req, .req_ready, .wdata_pop, .resp_valid, .resp_data, .resp_error, .bypass_active, .op_cut,
        .dq_in, .dq_out, .dq_oe, .addr_pin, .chip_select_n, .write_strobe_n, .output_enable_n,
        .hardware_clear_n, .accel_hv_en, .width_select_n);
    nfh_flash_model u_flash (.dq_out, .dq_oe, .addr_pin, .chip_select_n, .write_strobe_n, .output_enable_n,
        .hardware_clear_n, .dq_in, .wr_cnt, .bad_cnt, .last_sect);
    always #4 clock = ~clock;
    task automatic step;
        @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One request, raised for one cycle once ready; n gives the write cycles it cost
    task automatic op(input nfh_op_t o, input logic [21:0] a, input logic [15:0] d);
        int n0;
        n0 = wr_cnt;
        for (k = 0; k < 100 && req_ready !== 1'b1; k++) step();
        req_op = o;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        step();
        req_valid = 1'b0;
        if (o == NFH_OP_BUF_PROG) req_data = req_data + 16'h0001;  // First word taken at acceptance
        for (k = 0; k < 5000 && resp_valid !== 1'b1; k++)
        begin
            if (wdata_pop === 1'b1) req_data = req_data + 16'h0001;
            step();
        end
        if (k == 5000) chk(32'h0, 32'h1);
        got_d = resp_data;
        got_e = resp_error;
        n = wr_cnt - n0;
    endtask
    task automatic t_basic;
        chk(hardware_clear_n, 1'b1);
        chk({op_cut, width_select_n}, 2'b01);
        op(NFH_OP_READ, 22'h000040, 16'h0000);
        chk(got_d, 16'hffff);
        op(NFH_OP_PROG, 22'h012345, 16'h1234);
        chk(n, 4);
        op(NFH_OP_READ, 22'h012345, 16'h0000);
        chk(got_d, 16'h1234);
        op(NFH_OP_BYP_ENTER, 22'h000000, 16'h0000);
        chk(bypass_active, 1'b1);
        op(NFH_OP_PROG, 22'h000100, 16'h4321);
        chk(n, 2);
        op(NFH_OP_EXIT, 22'h000000, 16'h0000);
        op(NFH_OP_READ, 22'h000100, 16'h0000);
        chk(got_d, 16'h4321);
        chk(bypass_active, 1'b0);
        $display("program test done");
    endtask
    task automatic t_ident;
        op(NFH_OP_IDENT, 22'h000000, 16'h0000);
        op(NFH_OP_READ, 22'h000000, 16'h0000);
        chk(got_d, 16'h005a);
        op(NFH_OP_EXIT, 22'h000000, 16'h0000);
        op(NFH_OP_READ, 22'h012345, 16'h0000);
        chk(got_d, 16'h1234);
        $display("ident test done");
    endtask
    task automatic t_erase;
        op(NFH_OP_ERASE_SECT, 22'h3f8000, 16'h0000);
        chk(n, 6);
        chk(last_sect, 6'h3f);
        req_sect_mask = 64'h0000000000000024;
        op(NFH_OP_ERASE_MORE, 22'h000000, 16'h0000);
        chk(n, 7);
        chk(last_sect, 6'h05);
        op(NFH_OP_ERASE_CHIP, 22'h000000, 16'h0000);
        chk(n, 6);
        req_sect_mask = 64'h0000000000000000;
        op(NFH_OP_ERASE_MORE, 22'h000000, 16'h0000);
        chk({got_e, 8'(n)}, 9'h100);
        $display("erase test done");
    endtask
    task automatic t_buf;
        req_count = 5'h0f;
        op(NFH_OP_BUF_PROG, 22'h020000, 16'h0100);
        chk({got_e, 8'(n)}, 9'h015);
        op(NFH_OP_READ, 22'h02000f, 16'h0000);
        chk(got_d, 16'h010f);
        req_count = 5'h10;
        op(NFH_OP_BUF_PROG, 22'h020000, 16'h0100);
        chk({got_e, 8'(n)}, 9'h100);
        $display("buffer test done");
    endtask
    task automatic t_clear_accel;
        op(NFH_OP_IDENT, 22'h000000, 16'h0000);
        op(NFH_OP_CLEAR, 22'h000000, 16'h0000);
        op(NFH_OP_READ, 22'h000040, 16'h0000);
        chk(got_d, 16'hffff);
        accel_req = 1'b1;
        for (k = 0; k < 50 && bypass_active !== 1'b1; k++) step();
        chk({accel_hv_en, bypass_active}, 2'b11);
        op(NFH_OP_PROG, 22'h000200, 16'h5678);
        chk(n, 2);
        accel_req = 1'b0;
        for (k = 0; k < 50 && bypass_active !== 1'b0; k++) step();
        chk({accel_hv_en, bypass_active}, 2'b00);
        op(NFH_OP_READ, 22'h000200, 16'h0000);
        chk(got_d, 16'h5678);
        chk(bad_cnt, 0);
        $display("clear and accel test done");
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Whole run is under ten microseconds
    initial
    begin
        #400000;
        err_count++;
        summarize();
    end
    initial
    begin
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        t_basic();
        t_ident();
        t_erase();
        t_buf();
        t_clear_accel();
        summarize();
    end
endmodule
`default_nettype wire
